/* rtl/emb_bus_ctrl.sv */
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - single-chip mode: control register writes ignored
// - disable bit clear: bus owns pins, ports suppressed
// - disable bit set: pins are ports except in bus cycles
// - control register resets to zero; bits 6, 3, 2 read zero
// - write configuration ignored with an 8-bit data bus
// - word write: even byte held, odd write drives word
// - byte select: byte on both halves, high strobe, one byte enable
// - wait field 11/10/01/00 adds 0/1/2/3 instruction cycles
// - wait cycles follow the operation's instruction cycle
// - data width bit: set 16 bits, clear 8 bits
// - address width field selects 20/16/12/8 lines, 10 is 16
// - unused high address lines are ports, disable bit ignored
// - widths fixed by configuration, not by software
// - narrow address with 16-bit data loses upper data bits
// - data shares low lines; lines 16 to 19 carry address only
// - byte address line is the address lsb, reaching 2 Mbyte
// - upper and lower byte enable outputs
// - 21-bit addressing in 8-bit mode and byte select mode
// - idle: lines released, strobes high, latch and lsb low
// - byte write: byte on both halves, strobe by pointer lsb
module emb_bus_ctrl #(
  parameter int TCY_CLKS = emb_pkg::TCY_CLKS
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // configuration and mode
  input  wire logic        data_width_cfg,
  input  wire logic [1:0]  address_width_cfg,
  input  wire logic        single_chip_mode,
  // table engine side
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic [20:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  // memory pins
  input  wire logic [15:0] ad_in,
  output logic [15:0]      ad_out,
  output logic [15:0]      ad_oe,
  output logic [3:0]       a_hi_out,
  output logic [3:0]       a_hi_oe,
  output logic             addr_latch_enable,
  output logic             output_enable_n,
  output logic             write_strobe_high_n,
  output logic             write_strobe_low_n,
  output logic             upper_byte_enable_n,
  output logic             lower_byte_enable_n,
  output logic             byte_address_lsb,
  output logic             chip_enable_n,
  // pin ownership
  output logic [19:0]      line_owned,
  output logic             ctrl_owned
);

  localparam int PW = $clog2(TCY_CLKS);
  localparam logic [PW-1:0] PH_END = PW'(TCY_CLKS - 1);

  typedef enum {
    ST_IDLE, ST_ADDR, ST_LATCH, ST_STROBE, ST_WAIT, ST_TAIL
  } emb_state_type;

  // ****************************************
  // declarations
  // ****************************************
  emb_state_type  state_reg;
  logic [7:0]     ctrl;
  logic [7:0]     status;
  logic           cfg_done_reg;
  logic           data16_reg;
  logic [1:0]     adw_reg;
  logic [15:0]    ad_meta_reg;
  logic [15:0]    ad_sync_reg;
  logic [PW-1:0]  phase_reg;
  logic           tcy_end;
  logic           fire;
  logic           op_write_reg;
  logic [20:0]    op_addr_reg;
  logic [7:0]     op_wdata_reg;
  logic [1:0]     op_wm_reg;
  logic [7:0]     hold_byte_reg;
  logic [1:0]     tail_reg;
  logic           wait_expired;
  logic           wait_last;
  logic [19:0]    addr_mask;
  logic [15:0]    data_mask;
  logic [19:0]    line_out_next;
  logic [19:0]    line_oe_next;
  logic           ale_next;
  logic           oe_n_next;
  logic           wrh_n_next;
  logic           wrl_n_next;
  logic           ub_n_next;
  logic           lb_n_next;
  logic           ba0_next;
  logic           ce_n_next;
  logic [19:0]    owned_next;
  logic           data_drive;
  logic [15:0]    wr_word;
  logic           wr_hi_sel;
  logic           wr_lo_sel;
  logic           ub_sel;
  logic           lb_sel;

  // ****************************************
  // register file
  // ****************************************
  emb_axil_regs u_regs (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .awaddr     (awaddr),
    .awvalid    (awvalid),
    .awready    (awready),
    .wdata      (wdata),
    .wstrb      (wstrb),
    .wvalid     (wvalid),
    .wready     (wready),
    .bresp      (bresp),
    .bvalid     (bvalid),
    .bready     (bready),
    .araddr     (araddr),
    .arvalid    (arvalid),
    .arready    (arready),
    .rdata      (rdata),
    .rresp      (rresp),
    .rvalid     (rvalid),
    .rready     (rready),
    .write_lock (single_chip_mode),
    .status     (status),
    .ctrl       (ctrl)
  );

  // status word
  always_comb
  begin
    status = 8'h00;
    status[emb_pkg::STAT_BUSY]   = (state_reg != ST_IDLE);
    status[emb_pkg::STAT_SINGLE] = single_chip_mode;
    status[emb_pkg::STAT_DATA16] = data16_reg;
    status[emb_pkg::STAT_ADW_HI:emb_pkg::STAT_ADW_LO] = adw_reg;
    status[emb_pkg::STAT_OWNED]  = ctrl_owned;
  end

  // ****************************************
  // configuration capture
  // ****************************************
  // widths caught once after reset release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_done_reg <= 1'b0;
      data16_reg   <= emb_pkg::BW_RESET;
      adw_reg      <= emb_pkg::ADW_RESET;
    end
    else if (!cfg_done_reg)
    begin
      cfg_done_reg <= 1'b1;
      data16_reg   <= data_width_cfg;
      adw_reg      <= address_width_cfg;
    end
  end

  assign addr_mask = emb_pkg::emb_line_mask(adw_reg);
  assign data_mask = data16_reg ? 16'hffff : 16'h00ff;

  // ****************************************
  // pin input synchroniser
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ad_meta_reg <= 16'h0000;
      ad_sync_reg <= 16'h0000;
    end
    else
    begin
      ad_meta_reg <= ad_in;
      ad_sync_reg <= ad_meta_reg;
    end
  end

  // ****************************************
  // instruction cycle divider
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase_reg <= '0;
    else if (tcy_end)
      phase_reg <= '0;
    else
      phase_reg <= phase_reg + PW'(1);
  end

  assign tcy_end = (phase_reg == PH_END);

  // operations start on an instruction cycle edge
  assign req_ready = (state_reg == ST_IDLE) && tcy_end && cfg_done_reg
                     && !single_chip_mode;
  assign fire      = req_valid && req_ready;

  // ****************************************
  // operation capture
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op_write_reg <= 1'b0;
      op_addr_reg  <= 21'h0;
      op_wdata_reg <= 8'h00;
      op_wm_reg    <= 2'h0;
    end
    else if (fire)
    begin
      op_write_reg <= req_write;
      op_addr_reg  <= req_addr;
      op_wdata_reg <= req_wdata;
      op_wm_reg    <= ctrl[emb_pkg::WM_HI:emb_pkg::WM_LO];
    end
  end

  // even word-write byte held for odd partner
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hold_byte_reg <= 8'h00;
    else if (state_reg == ST_ADDR && op_write_reg && data16_reg
             && op_wm_reg[1] && !op_addr_reg[0])
      hold_byte_reg <= op_wdata_reg;
  end

  // ****************************************
  // wait states
  // ****************************************
  emb_wait_timer u_wait (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .load      (fire),
    .wait_code (ctrl[emb_pkg::WAIT_HI:emb_pkg::WAIT_LO]),
    .tick      (state_reg == ST_WAIT && tcy_end),
    .expired   (wait_expired),
    .last      (wait_last)
  );

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_IDLE;
      tail_reg  <= 2'h0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (fire)
            state_reg <= ST_ADDR;
        ST_ADDR:
          state_reg <= ST_LATCH;
        ST_LATCH:
          state_reg <= ST_STROBE;
        ST_STROBE:
          if (tcy_end)
            state_reg <= wait_expired ? ST_TAIL : ST_WAIT;
        ST_WAIT:
          if (tcy_end && wait_last)
            state_reg <= ST_TAIL;
        ST_TAIL:
          if (tail_reg == emb_pkg::TAIL_CLKS - 2'h1)
            state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
      tail_reg <= (state_reg == ST_TAIL) ? tail_reg + 2'h1 : 2'h0;
    end
  end

  // answer once strobe data has crossed the synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (state_reg == ST_TAIL && tail_reg == emb_pkg::TAIL_CLKS - 2'h1)
      begin
        rsp_valid <= 1'b1;
        if (!op_write_reg)
          rsp_rdata <= ad_sync_reg & data_mask & addr_mask[15:0];
      end
    end
  end

  // ****************************************
  // write configuration decode
  // ****************************************
  always_comb
  begin
    data_drive = 1'b1;
    wr_word    = {op_wdata_reg, op_wdata_reg};
    wr_hi_sel  = 1'b0;
    wr_lo_sel  = 1'b0;
    ub_sel     = 1'b1;
    lb_sel     = 1'b1;
    if (!data16_reg)
    begin
      wr_word   = {8'h00, op_wdata_reg};
      wr_lo_sel = 1'b1;
      ub_sel    = 1'b0;
    end
    else if (op_wm_reg[1])
    begin
      data_drive = op_addr_reg[0];
      wr_word    = {op_wdata_reg, hold_byte_reg};
      wr_hi_sel  = op_addr_reg[0];
    end
    else if (op_wm_reg == emb_pkg::WM_BSEL)
    begin
      wr_hi_sel = 1'b1;
      ub_sel    = op_addr_reg[0];
      lb_sel    = !op_addr_reg[0];
    end
    else
    begin
      wr_hi_sel = op_addr_reg[0];
      wr_lo_sel = !op_addr_reg[0];
    end
  end

  // ****************************************
  // pin values
  // ****************************************
  always_comb
  begin
    line_out_next = 20'h0;
    line_oe_next  = 20'h0;
    ale_next      = 1'b0;
    oe_n_next     = 1'b1;
    wrh_n_next    = 1'b1;
    wrl_n_next    = 1'b1;
    ub_n_next     = 1'b1;
    lb_n_next     = 1'b1;
    ba0_next      = 1'b0;
    ce_n_next     = 1'b1;
    if (state_reg != ST_IDLE)
    begin
      ce_n_next     = 1'b0;
      ba0_next      = op_addr_reg[0];
      line_out_next = op_addr_reg[20:1];
      line_oe_next  = addr_mask;
      if (state_reg == ST_ADDR)
        ale_next = 1'b1;
      else if (state_reg != ST_LATCH)
      begin
        // data phase frees shared low lines
        line_oe_next[15:0] = addr_mask[15:0] & ~data_mask;
        if (state_reg != ST_TAIL)
        begin
          ub_n_next = !(ub_sel && data16_reg);
          lb_n_next = !lb_sel;
          if (!op_write_reg)
            oe_n_next = 1'b0;
          else
          begin
            wrh_n_next = !wr_hi_sel;
            wrl_n_next = !wr_lo_sel;
            if (data_drive)
            begin
              line_out_next[15:0] = (op_addr_reg[16:1] & ~data_mask)
                                    | (wr_word & data_mask);
              line_oe_next[15:0]  = addr_mask[15:0];
            end
          end
        end
      end
    end
  end

  // bus claims its lines unless in single-chip mode, or disabled and idle
  always_comb
  begin
    owned_next = addr_mask;
    if (single_chip_mode)
      owned_next = 20'h0;
    else if (ctrl[emb_pkg::BUS_DIS] && state_reg == ST_IDLE)
      owned_next = 20'h0;
  end

  // registered pin drivers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ad_out              <= 16'h0000;
      ad_oe               <= 16'h0000;
      a_hi_out            <= 4'h0;
      a_hi_oe             <= 4'h0;
      addr_latch_enable   <= 1'b0;
      output_enable_n     <= 1'b1;
      write_strobe_high_n <= 1'b1;
      write_strobe_low_n  <= 1'b1;
      upper_byte_enable_n <= 1'b1;
      lower_byte_enable_n <= 1'b1;
      byte_address_lsb    <= 1'b0;
      chip_enable_n       <= 1'b1;
      line_owned          <= 20'h00000;
      ctrl_owned          <= 1'b0;
    end
    else
    begin
      ad_out              <= line_out_next[15:0];
      ad_oe               <= line_oe_next[15:0];
      a_hi_out            <= line_out_next[19:16];
      a_hi_oe             <= line_oe_next[19:16];
      addr_latch_enable   <= ale_next;
      output_enable_n     <= oe_n_next;
      write_strobe_high_n <= wrh_n_next;
      write_strobe_low_n  <= wrl_n_next;
      upper_byte_enable_n <= ub_n_next;
      lower_byte_enable_n <= lb_n_next;
      byte_address_lsb    <= ba0_next;
      chip_enable_n       <= ce_n_next;
      line_owned          <= owned_next;
      ctrl_owned          <= (owned_next != 20'h00000);
    end
  end

endmodule : emb_bus_ctrl
`default_nettype wire

/* rtl/emb_pkg.sv */
package emb_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hb3;
  localparam int         BUS_DIS    = 7;
  localparam int         WAIT_HI    = 5;
  localparam int         WAIT_LO    = 4;
  localparam int         WM_HI      = 1;
  localparam int         WM_LO      = 0;

  // ****************************************
  // status fields
  // ****************************************
  localparam int STAT_BUSY   = 0;
  localparam int STAT_SINGLE = 1;
  localparam int STAT_DATA16 = 2;
  localparam int STAT_ADW_LO = 3;
  localparam int STAT_ADW_HI = 4;
  localparam int STAT_OWNED  = 5;

  // ****************************************
  // encodings and reset values
  // ****************************************
  localparam logic [1:0] WM_BSEL   = 2'h1;
  localparam logic [1:0] ADW_20    = 2'h3;
  localparam logic [1:0] ADW_16    = 2'h2;
  localparam logic [1:0] ADW_12    = 2'h1;
  localparam logic       BW_RESET  = 1'h1;
  localparam logic [1:0] ADW_RESET = 2'h3;
  localparam logic [19:0] MASK_20  = 20'hfffff;
  localparam logic [19:0] MASK_16  = 20'h0ffff;
  localparam logic [19:0] MASK_12  = 20'h00fff;
  localparam logic [19:0] MASK_8   = 20'h000ff;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************
  // timing counts
  // ****************************************
  localparam int         TCY_CLKS  = 4;
  localparam logic [1:0] TAIL_CLKS = 2'h3;

  // wait field code to added cycles
  function automatic logic [1:0] emb_wait_tcy(input logic [1:0] code);
    return ~code;
  endfunction : emb_wait_tcy

  // lines claimed per address width
  function automatic logic [19:0] emb_line_mask(input logic [1:0] adw);
    case (adw)
      ADW_20:  return MASK_20;
      ADW_16:  return MASK_16;
      ADW_12:  return MASK_12;
      default: return MASK_8;
    endcase
  endfunction : emb_line_mask

endpackage : emb_pkg

/* rtl/emb_wait_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module emb_wait_timer
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // control
  input  wire logic       load,
  input  wire logic [1:0] wait_code,
  input  wire logic       tick,
  // state
  output logic            expired,
  output logic            last
);

  logic [1:0] count_reg;

  // counts whole instruction cycles of wait
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_reg <= 2'h0;
    else if (load)
      count_reg <= emb_pkg::emb_wait_tcy(wait_code);
    else if (tick && count_reg != 2'h0)
      count_reg <= count_reg - 2'h1;
  end

  assign expired = (count_reg == 2'h0);
  assign last    = (count_reg == 2'h1);

endmodule : emb_wait_timer
`default_nettype wire

/* rtl/emb_axil_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module emb_axil_regs
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // block side
  input  wire logic        write_lock,
  input  wire logic [7:0]  status,
  output logic [7:0]       ctrl
);

  logic       aw_got_reg;
  logic [7:0] aw_addr_reg;
  logic       w_got_reg;
  logic [7:0] w_data_reg;
  logic       w_strb_reg;
  logic       commit;

  assign awready = !aw_got_reg;
  assign wready  = !w_got_reg;
  assign arready = !rvalid;
  assign commit  = aw_got_reg && w_got_reg && !bvalid;

  // address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_got_reg   <= 1'b0;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      else if (commit)
        aw_got_reg <= 1'b0;
      if (wvalid && wready)
      begin
        w_got_reg  <= 1'b1;
        w_data_reg <= wdata[7:0];
        w_strb_reg <= wstrb[0];
      end
      else if (commit)
        w_got_reg <= 1'b0;
    end
  end

  // control register, write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl   <= emb_pkg::CTRL_RESET;
      bvalid <= 1'b0;
      bresp  <= emb_pkg::RESP_OKAY;
    end
    else if (commit)
    begin
      bvalid <= 1'b1;
      bresp  <= emb_pkg::RESP_OKAY;
      if (aw_addr_reg == emb_pkg::CTRL_OFS)
      begin
        if (!write_lock && w_strb_reg)
          ctrl <= w_data_reg & emb_pkg::CTRL_WMASK;
      end
      else if (aw_addr_reg != emb_pkg::STAT_OFS)
        bresp <= emb_pkg::RESP_DECERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // read answer a cycle after address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= emb_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp  <= emb_pkg::RESP_OKAY;
      rdata  <= 32'h0;
      if (araddr == emb_pkg::CTRL_OFS)
        rdata[7:0] <= write_lock ? 8'h00 : ctrl;
      else if (araddr == emb_pkg::STAT_OFS)
        rdata[7:0] <= status;
      else
        rresp <= emb_pkg::RESP_DECERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

endmodule : emb_axil_regs
`default_nettype wire

/* tb/emb_bus_ctrl_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// bus control checker
// ****
module emb_bus_ctrl_monitor #(
  parameter int TCY_CLKS = 4
)
(
  // clock, reset, requests
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [20:0] req_addr,
  input wire logic        rsp_valid,
  input wire logic        single_chip_mode,
  // memory pins
  input wire logic [15:0] ad_oe,
  input wire logic [3:0]  a_hi_oe,
  input wire logic [19:0] line_owned,
  input wire logic        addr_latch_enable,
  input wire logic        output_enable_n,
  input wire logic        write_strobe_high_n,
  input wire logic        write_strobe_low_n,
  input wire logic        upper_byte_enable_n,
  input wire logic        lower_byte_enable_n,
  input wire logic        byte_address_lsb,
  input wire logic        chip_enable_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // request taken
  wire logic take = req_valid && req_ready;
  a_idle_pins: assert property (chip_enable_n |->
    &{output_enable_n, write_strobe_high_n, write_strobe_low_n,
    upper_byte_enable_n, lower_byte_enable_n} && !addr_latch_enable
    && !byte_address_lsb) else $error("idle pins wrong");
  a_ale_pulse: assert property (take |->
    ##2 addr_latch_enable ##1 !addr_latch_enable) else $error("ale");
  a_lsb_line: assert property (take |->
    ##2 byte_address_lsb == $past(req_addr[0], 2)) else $error("ba lsb");
  a_answer_bound: assert property (take |-> ##[8:20] rsp_valid)
    else $error("no answer");
  a_single_idle: assert property (single_chip_mode |-> !req_ready)
    else $error("ready in single chip");
  a_single_lines: assert property (single_chip_mode &&
    $past(single_chip_mode) |-> line_owned == 20'h0) else $error("owned");
  a_owned_drive: assert property (({a_hi_oe, ad_oe} & ~line_owned)
    == 20'h0) else $error("drives unowned line");
  a_read_released: assert property (!output_enable_n |->
    ad_oe[7:0] == 8'h0 && write_strobe_high_n && write_strobe_low_n)
    else $error("drive during read");
  c_take: cover property (take);
  c_answer: cover property (rsp_valid);
  c_write: cover property (!write_strobe_high_n);
endmodule : emb_bus_ctrl_monitor
bind emb_bus_ctrl emb_bus_ctrl_monitor #(.TCY_CLKS(TCY_CLKS)) u_mon (.*);
`default_nettype wire

/* tb/emb_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// external memory
// ****
module emb_mem_model
(
  // bus pins
  input wire logic        aclk,
  input wire logic [15:0] ad_out,
  input wire logic [3:0]  a_hi_out,
  input wire logic        addr_latch_enable,
  input wire logic        output_enable_n,
  input wire logic        write_strobe_high_n,
  input wire logic        write_strobe_low_n,
  input wire logic        upper_byte_enable_n,
  input wire logic        lower_byte_enable_n,
  input wire logic [1:0]  slow,
  output logic [15:0]     ad_in,
  // last write seen
  output logic [15:0]     wr_data,
  output logic [3:0]      wr_ctl
);
  logic [19:0] addr_q = 20'h0;
  logic [1:0]  oe_cnt = 2'h0;
  logic [15:0] last_q = 16'h0;
  // data after access time
  assign ad_in = (!output_enable_n && oe_cnt >= slow) ?
    addr_q[15:0] ^ 16'ha5c3 : ~last_q;
  // latch address, record writes
  always_ff @(posedge aclk)
  begin
    last_q <= ad_in;
    oe_cnt <= output_enable_n ? 2'h0 : oe_cnt + {1'h0, oe_cnt != 2'h3};
    if (addr_latch_enable)
    begin
      addr_q <= {a_hi_out, ad_out};
      wr_ctl <= 4'h0;
    end
    else if (!write_strobe_high_n || !write_strobe_low_n)
    begin
      wr_data <= ad_out;
      wr_ctl  <= ~{write_strobe_high_n, write_strobe_low_n,
                   upper_byte_enable_n, lower_byte_enable_n};
    end
  end
endmodule : emb_mem_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// bus control bench
// ****
module tb_top;
  logic        aclk = 1'h0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready, ctrl_owned;
  logic        awready, wready, bvalid, arready, rvalid, data_width_cfg;
  logic        single_chip_mode, req_valid, req_ready, req_write, rsp_valid;
  logic        addr_latch_enable, output_enable_n, write_strobe_high_n;
  logic        write_strobe_low_n, upper_byte_enable_n, lower_byte_enable_n;
  logic        byte_address_lsb, chip_enable_n;
  logic [7:0]  awaddr, araddr, req_wdata;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, a_hi_out, a_hi_oe, wr_ctl;
  logic [1:0]  bresp, rresp, address_width_cfg, slow;
  logic [20:0] req_addr;
  logic [15:0] rsp_rdata, ad_in, ad_out, ad_oe, wr_data;
  logic [19:0] line_owned;
  int          fails = 0;
  int          checked = 0;
  emb_bus_ctrl dut (.*);
  emb_mem_model u_mem (.*);
  // clock
  always #50 aclk = ~aclk;
  // compare and report
  task automatic chk(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // register bus cycles
  task automatic axi_wr(input logic [7:0] a, d, input logic [1:0] r);
    {awaddr, wdata, awvalid, wvalid} <= {a, 24'h0, d, 2'h3};
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    chk(bresp, r);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, e,
                        input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    chk(rdata & m, e);
    chk(rresp, r);
  endtask : axi_rd
  // table operation, k = clocks to answer
  task automatic tbl(input logic w, input logic [20:0] a,
                     input logic [7:0] b, output int k);
    {req_write, req_addr, req_wdata, req_valid} <= {w, a, b, 1'h1};
    do @(posedge aclk); while (!req_ready);
    req_valid <= 1'h0;
    k = 0;
    do
    begin
      @(posedge aclk);
      k++;
    end
    while (!rsp_valid && k < 40);
  endtask : tbl
  // expected {high, low, upper, lower} strobes
  function automatic logic [3:0] exp_ctl(input logic [1:0] wm,
                                         input logic odd, input logic w16);
    if (!w16)
      return 4'h5;
    if (wm[1])
      return odd ? 4'hb : 4'h0;
    if (wm[0])
      return odd ? 4'ha : 4'h9;
    return odd ? 4'hb : 4'h7;
  endfunction : exp_ctl
  // main sequence
  initial
  begin
    int k, code;
    logic [20:0] a;
    logic [7:0]  b, held;
    {aresetn, awvalid, wvalid, arvalid, req_valid, req_write} = 6'h0;
    {bready, rready, single_chip_mode, data_width_cfg} = 4'hd;
    {awaddr, araddr, req_wdata, wdata, slow} = 58'h0;
    {wstrb, address_width_cfg, req_addr} = {4'hf, 2'h3, 21'h0};
    void'($urandom(32'h0b1dddc0));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(8'h00, 32'hffffffff, 32'h0, 2'h0);
    axi_wr(8'h00, 8'hff, 2'h0);
    axi_rd(8'h00, 32'hffffffff, 32'hb3, 2'h0);
    chk({ctrl_owned, line_owned}, 21'h0);
    axi_wr(8'h08, 8'h0, 2'h3);
    axi_rd(8'h08, 32'hffffffff, 32'h0, 2'h3);
    axi_rd(8'h04, 32'h1e, 32'h1c, 2'h0);
    for (code = 0; code < 4; code++)
    begin
      axi_wr(8'h00, {2'h2, code[1:0], 4'h0}, 2'h0);
      slow <= (code == 3) ? 2'h0 : 2'h2;
      a = 21'($urandom);
      tbl(1'h0, a, 8'h0, k);
      chk(k, 8 + 4 * (3 - code));
      chk(rsp_rdata, a[16:1] ^ 16'ha5c3);
    end
    for (code = 0; code < 3; code++)
    begin
      axi_wr(8'h00, 8'h30 | code[1:0], 2'h0);
      a = {20'($urandom), 1'h0};
      held = 8'($urandom);
      b = 8'($urandom);
      tbl(1'h1, a, held, k);
      chk(wr_ctl, exp_ctl(code[1:0], 1'h0, 1'h1));
      tbl(1'h1, a | 21'h1, b, k);
      chk(wr_ctl, exp_ctl(code[1:0], 1'h1, 1'h1));
      chk(wr_data, {b, code[1] ? held : b});
    end
    chk({ctrl_owned, line_owned}, 21'h1fffff);
    single_chip_mode <= 1'h1;
    axi_wr(8'h00, 8'h80, 2'h0);
    axi_rd(8'h00, 32'hff, 32'h0, 2'h0);
    chk({req_ready, ctrl_owned, line_owned}, 22'h0);
    single_chip_mode <= 1'h0;
    axi_rd(8'h00, 32'hff, 32'h32, 2'h0);
    {data_width_cfg, address_width_cfg, aresetn} <= 4'h4;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    data_width_cfg <= 1'h1;
    chk({ctrl_owned, line_owned}, 21'h10ffff);
    axi_rd(8'h04, 32'h1e, 32'h10, 2'h0);
    axi_wr(8'h00, 8'h32, 2'h0);
    tbl(1'h1, 21'($urandom) | 21'h1, b, k);
    chk(wr_ctl, exp_ctl(2'h2, 1'h1, 1'h0));
    chk(wr_data[7:0], b);
    end_of_test;
  end
  // watchdog
  initial
  begin
    #800000;
    fails++;
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
